// ### hw/bie_defs.svh
// Purpose: constants for the inc/dec/branch execute block
// Assumes: 12-bit instruction word, 8-bit data, 11-bit program counter
// Notes:   opcode patterns are masks plus match values
`ifndef BIE_DEFS_SVH
`define BIE_DEFS_SVH

`define BIE_INSN_W        12
`define BIE_DATA_W        8
`define BIE_PC_W          11
`define BIE_FADDR_W       5
// decrement file: 0000 11df ffff
`define BIE_DEC_MASK      12'hfc0
`define BIE_DEC_MATCH     12'h0c0
// increment file: 0010 10df ffff
`define BIE_INC_MASK      12'hfc0
`define BIE_INC_MATCH     12'h280
// increment, skip if zero: 0011 11df ffff
`define BIE_INCSZ_MASK    12'hfc0
`define BIE_INCSZ_MATCH   12'h3c0
// unconditional branch: 101k kkkk kkkk
`define BIE_BR_MASK       12'he00
`define BIE_BR_MATCH      12'ha00
// field positions
`define BIE_DEST_BIT      5
`define BIE_FADDR_HI      4
`define BIE_LIT_HI        8
`define BIE_PAGE_HI       6
`define BIE_PAGE_LO       5
`define BIE_ONE           8'h01
`define BIE_ZERO          8'h00
`define BIE_NOP           12'h000

`endif

// ### hw/bie_pkg.sv
// Purpose: types for the inc/dec/branch execute block
// Assumes: constants come from bie_defs.svh
// Notes:   one-hot execute states
`include "bie_defs.svh"
package bie_pkg;
    // execute state, one-hot
    typedef enum logic [1:0] {
        BIE_RUN   = 2'b01,
        BIE_FLUSH = 2'b10
    } bie_state_type;

    // result of one executed instruction
    typedef struct packed {
        logic [`BIE_DATA_W-1:0]  data;    // result value
        logic                    to_file; // 1: file register, 0: accumulator
        logic                    wr_acc;  // accumulator write strobe
        logic                    wr_file; // file register write strobe
        logic [`BIE_FADDR_W-1:0] faddr;   // file address
    } bie_result_type;
endpackage

// ### hw/bie_step.sv
// Purpose: 8-bit plus/minus one with zero detect
// Assumes: pure combinational
// Notes:   wraps at the data width
`timescale 1ns/100ps
module bie_step #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] val_in,  // operand
    input  wire logic         down_in, // 1 subtracts one
    output logic      [W-1:0] res_out, // wrapped result
    output logic              zero_out // result is zero
);
    // add or subtract one, wrap is natural
    always_comb begin
        if (down_in) begin
            res_out = W'(val_in - W'(1));
        end else begin
            res_out = W'(val_in + W'(1));
        end
        zero_out = (res_out == '0);
    end
endmodule

// ### hw/bie_exec.sv
// Purpose: decode and execute of dec, inc, inc-skip and branch
// Assumes: file operand and status fed by core on same clock
// Notes:   one instruction per cycle when insn_valid_in is high and busy_out is low
// Summary of operation
// - decrement file, route by d, set zero
// - branch loads literal into pc 8..0
// - branch takes pc 10..9 from page bits
// - branch takes two cycles, flushes prefetch
// - increment file wraps, route by d, zero
// - increment-skip routes by d, flags untouched
// - increment-skip zero result skips prefetch as nop
`timescale 1ns/100ps
`include "bie_defs.svh"
module bie_exec
    import bie_pkg::*;
#(
    parameter int DW = `BIE_DATA_W,
    parameter int PW = `BIE_PC_W
) (
    input  wire logic                   core_clk_in,    // core clock
    input  wire logic                   resetn_in,      // sync reset, low
    input  wire logic [`BIE_INSN_W-1:0] insn_in,        // decoded word
    input  wire logic                   insn_valid_in,  // word present
    input  wire logic [DW-1:0]          file_data_in,   // operand of f
    input  wire logic [DW-1:0]          status_in,      // status register
    output logic      [DW-1:0]          result_out,     // result value
    output logic                        acc_we_out,     // accumulator write
    output logic                        file_we_out,    // file write
    output logic [`BIE_FADDR_W-1:0]     file_addr_out,  // file address
    output logic                        zero_we_out,    // zero flag update
    output logic                        zero_out,       // new zero flag
    output logic                        pc_load_out,    // load new pc
    output logic      [PW-1:0]          pc_target_out,  // branch target
    output logic                        squash_out,     // prefetch -> nop
    output logic                        busy_out        // second cycle
);
    // one word is taken at each edge where insn_valid_in is high and
    // busy_out is low; every output answers one edge later

    // flow group: execute state and the pulses it drives
    bie_state_type  state;            // execute state
    bie_state_type  next_state;       // next execute state
    logic           busy;             // registered flushed-slot flag
    logic           next_busy;        // next flushed-slot flag
    logic           squash;           // registered squash pulse
    logic           next_squash;      // next squash pulse
    logic           pc_load;          // registered pc load pulse
    logic           next_pc_load;     // next pc load pulse
    logic [PW-1:0]  pc_tgt;           // registered branch target
    logic [PW-1:0]  next_pc_tgt;      // next branch target

    // result group: value, route and zero flag
    bie_result_type res;              // registered result
    bie_result_type next_res;         // next result
    logic           zero_we;          // registered zero update pulse
    logic           next_zero_we;     // next zero update pulse
    logic           zero_f;           // registered zero value
    logic           next_zero_f;      // next zero value

    // decode helpers, all combinational
    // they only look at the word that is really executed
    logic           is_dec;           // decrement file decoded
    logic           is_inc;           // increment file decoded
    logic           is_incsz;         // increment, skip if zero
    logic           is_br;            // unconditional branch decoded
    logic           is_step;          // any of the three file ops
    logic           skip_taken;       // increment-skip hit zero
    logic [DW-1:0]  step_res;         // incremented/decremented
    logic           step_zero;        // step result is zero
    logic [`BIE_INSN_W-1:0] eff_insn; // word actually executed

    // a flushed slot executes as a nop, whatever word is presented;
    // this keeps the prefetched word from writing anything
    assign eff_insn = (state == BIE_FLUSH) ? `BIE_NOP : insn_in;

    // opcode decode by mask and match; other opcodes give no strobes
    assign is_dec   = insn_valid_in &&
        ((eff_insn & `BIE_DEC_MASK) == `BIE_DEC_MATCH);
    assign is_inc   = insn_valid_in &&
        ((eff_insn & `BIE_INC_MASK) == `BIE_INC_MATCH);
    assign is_incsz = insn_valid_in &&
        ((eff_insn & `BIE_INCSZ_MASK) == `BIE_INCSZ_MATCH);
    assign is_br    = insn_valid_in &&
        ((eff_insn & `BIE_BR_MASK) == `BIE_BR_MATCH);

    // the three file ops share routing and the step unit
    assign is_step    = is_dec || is_inc || is_incsz;

    // a skip fires only when the increment wraps to zero
    assign skip_taken = is_incsz && step_zero;

    // shared plus/minus one unit; down only for decrement
    // the result is wrapped to DW bits inside the unit
    bie_step #(
        .W (DW)
    ) u_step (
        .val_in   (file_data_in),  // operand of f
        .down_in  (is_dec),        // 1 subtracts one
        .res_out  (step_res),      // wrapped result
        .zero_out (step_zero)      // zero detect
    );

    // next values of the flow group
    // branch or taken skip turns the next slot into a nop; busy is a
    // flop of its own so that busy_out leaves a register ungated
    always_comb begin
        next_state   = BIE_RUN;     // default: back to run
        next_busy    = 1'h0;        // default: slot is live
        next_squash  = 1'h0;        // pulses last one cycle
        next_pc_load = 1'h0;
        next_pc_tgt  = pc_tgt;      // target holds between loads
        case (state)
            BIE_FLUSH: begin
                // discarded slot: nothing loaded, back to run
                next_state = BIE_RUN;
                next_busy  = 1'h0;
            end
            BIE_RUN: begin
                if (skip_taken) begin
                    // skip: next slot squashed, flags untouched
                    next_squash = 1'h1;
                    next_state  = BIE_FLUSH;
                    next_busy   = 1'h1;
                end
                if (is_br) begin
                    // target = page bits : 9-bit literal
                    next_pc_tgt  = PW'({status_in[`BIE_PAGE_HI:`BIE_PAGE_LO],
                                        eff_insn[`BIE_LIT_HI:0]});
                    next_pc_load = 1'h1;
                    next_squash  = 1'h1;
                    next_state   = BIE_FLUSH;
                    next_busy    = 1'h1;
                end
            end
            default: begin
                // stray code: fall back to run, load nothing
                next_state = BIE_RUN;
            end
        endcase
    end

    // register the flow group; reset leaves the pipe live and idle
    // pc_tgt keeps the last target; only pc_load says it is new
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            state   <= BIE_RUN;     // run, nothing to flush
            busy    <= 1'h0;
            squash  <= 1'h0;
            pc_load <= 1'h0;
            pc_tgt  <= '0;
        end else begin
            state   <= next_state;
            busy    <= next_busy;
            squash  <= next_squash;
            pc_load <= next_pc_load;
            pc_tgt  <= next_pc_tgt;
        end
    end

    // next values of the result group
    // data and address are always loaded; only the strobes say that
    // they mean anything, which keeps the write path free of muxes
    always_comb begin
        next_res         = '0;      // strobes low by default
        next_res.faddr   = eff_insn[`BIE_FADDR_HI:0];
        next_res.data    = step_res;
        next_res.to_file = eff_insn[`BIE_DEST_BIT];
        next_zero_we     = 1'h0;    // update is a one-cycle pulse
        next_zero_f      = zero_f;  // flag value holds
        case (state)
            BIE_RUN: begin
                if (is_step) begin
                    // destination bit selects accumulator or file
                    next_res.wr_file = eff_insn[`BIE_DEST_BIT];
                    next_res.wr_acc  = !eff_insn[`BIE_DEST_BIT];
                end
                if (is_dec || is_inc) begin
                    // zero flag follows result, either destination
                    next_zero_we = 1'h1;
                    next_zero_f  = step_zero;
                end
                if (is_incsz) begin
                    // increment-skip leaves every flag alone
                    next_zero_we = 1'h0;
                    next_zero_f  = zero_f;
                end
            end
            default: begin
                // flushed slot: nothing written, flag holds
                next_res.wr_acc  = 1'h0;
                next_res.wr_file = 1'h0;
            end
        endcase
    end

    // register the result group
    // zero_f keeps its value between updates, as the flag does
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            res     <= '0;          // no strobes out of reset
            zero_we <= 1'h0;
            zero_f  <= 1'h0;
        end else begin
            res     <= next_res;
            zero_we <= next_zero_we;
            zero_f  <= next_zero_f;
        end
    end

    // outputs straight from flip-flops, no gate in between
    // strobes stand one cycle; zero_out and pc_target_out hold
    assign result_out    = res.data;    // value, valid with a strobe
    assign acc_we_out    = res.wr_acc;
    assign file_we_out   = res.wr_file;
    assign file_addr_out = res.faddr;
    assign zero_we_out   = zero_we;
    assign zero_out      = zero_f;
    assign pc_load_out   = pc_load;
    assign pc_target_out = pc_tgt;
    assign squash_out    = squash;
    assign busy_out      = busy;        // own flop, no compare
endmodule

// ### bench/bie_exec_props.sv
// Purpose: result, route and flush checks for bie_exec
// Assumes: outputs answer one edge after a taken word
// Notes:   bound from the bench top file
`timescale 1ns/100ps
`include "bie_defs.svh"
module bie_exec_props (
    input wire logic        core_clk_in,
    input wire logic        resetn_in,
    input wire logic [11:0] insn_in,
    input wire logic        insn_valid_in,
    input wire logic [7:0]  file_data_in,
    input wire logic [7:0]  status_in,
    input wire logic [7:0]  result_out,
    input wire logic        acc_we_out,
    input wire logic        file_we_out,
    input wire logic        zero_we_out,
    input wire logic        zero_out,
    input wire logic        pc_load_out,
    input wire logic [10:0] pc_target_out,
    input wire logic        squash_out,
    input wire logic        busy_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    // word taken at this edge, split by opcode
    wire logic tk = insn_valid_in && !busy_out;
    wire logic dec = tk && (insn_in & `BIE_DEC_MASK) == `BIE_DEC_MATCH;
    wire logic inc = tk && (insn_in & `BIE_INC_MASK) == `BIE_INC_MATCH;
    wire logic isz = tk && (insn_in & `BIE_INCSZ_MASK) == `BIE_INCSZ_MATCH;
    wire logic br = tk && (insn_in & `BIE_BR_MASK) == `BIE_BR_MATCH;
    // flushed slot, then a normal one
    sequence s_flush; squash_out && busy_out ##1 !busy_out; endsequence
    sequence s_plain; !squash_out && !busy_out; endsequence
    a_dec_route: assert property (dec |=> zero_we_out &&
        result_out == $past(file_data_in) - 8'h01 &&
        file_we_out == $past(insn_in[5]) && acc_we_out != file_we_out)
        else $error("decrement result or route wrong");
    a_br_low: assert property (br |=> pc_load_out && !zero_we_out &&
        pc_target_out[8:0] == $past(insn_in[8:0]))
        else $error("branch literal wrong");
    a_br_page: assert property (br |=>
        pc_target_out[10:9] == $past(status_in[6:5]))
        else $error("branch page bits wrong");
    a_br_flush: assert property (br |=> s_flush)
        else $error("branch did not flush");
    a_inc_wrap: assert property (inc |=> zero_we_out &&
        result_out == $past(file_data_in) + 8'h01 &&
        file_we_out == $past(insn_in[5]) && acc_we_out != file_we_out)
        else $error("increment result or route wrong");
    a_skip_flags: assert property (isz |=> !zero_we_out &&
        result_out == $past(file_data_in) + 8'h01 &&
        file_we_out == $past(insn_in[5]) && acc_we_out != file_we_out)
        else $error("skip increment wrong");
    a_skip_zero: assert property (isz |=>
        if ($past(file_data_in) == 8'hff) s_flush else s_plain)
        else $error("skip slot wrong");
    a_zero_value: assert property (zero_we_out |->
        zero_out == (result_out == 8'h00))
        else $error("zero flag wrong");
endmodule

// ### bench/baseline_incdec_branch_exec_bench.sv
// Purpose: self-checking bench for bie_exec
// Assumes: inputs change 2 ns after each rising edge
// Notes:   fixed corners, then seeded random words
`timescale 1ns/100ps
`include "bie_defs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    fail_count++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module baseline_incdec_branch_exec_bench;
    logic        core_clk_in = 1'b0, resetn_in = 1'b0, insn_valid_in = 1'b0;
    logic [11:0] insn_in = 12'h000, op;        // word and opcode
    logic [7:0]  file_data_in = 8'h00, status_in = 8'h00, result_out;
    logic        acc_we_out, file_we_out, zero_we_out, zero_out;
    logic        pc_load_out, squash_out, busy_out;
    logic [4:0]  file_addr_out;
    logic [10:0] pc_target_out;
    logic [31:0] r;                            // random draw
    integer      seed = 32'h9e98, fail_count = 0, comparisons = 0, cyc = 0;
    logic [11:0] ops [5] = '{`BIE_DEC_MATCH, `BIE_INC_MATCH,
        `BIE_INCSZ_MATCH, `BIE_BR_MATCH, 12'h100};
    bie_exec dut_u (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .insn_in(insn_in), .insn_valid_in(insn_valid_in),
        .file_data_in(file_data_in), .status_in(status_in),
        .result_out(result_out), .acc_we_out(acc_we_out),
        .file_we_out(file_we_out), .file_addr_out(file_addr_out),
        .zero_we_out(zero_we_out), .zero_out(zero_out),
        .pc_load_out(pc_load_out), .pc_target_out(pc_target_out),
        .squash_out(squash_out), .busy_out(busy_out));
    initial forever #10 core_clk_in = ~core_clk_in;
    // cut a hang short
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // expected plus/minus one result, wrapping at eight bits
    function automatic logic [7:0] exp_step(input logic [11:0] i,
                                            input logic [7:0]  f);
        if ((i & `BIE_DEC_MASK) == `BIE_DEC_MATCH) return f - 8'h01;
        return f + 8'h01;
    endfunction
    // expected branch target: page bits above the literal
    function automatic logic [10:0] exp_tgt(input logic [11:0] i,
                                            input logic [7:0]  s);
        return {s[6:5], i[8:0]};
    endfunction
    // one word, outputs checked a cycle later; busy slot gets a junk word
    task automatic run(input logic [11:0] i, input logic [7:0] f, s);
        logic d, n, k, b, x;
        logic [7:0] v;
        d = (i & `BIE_DEC_MASK) == `BIE_DEC_MATCH;
        n = (i & `BIE_INC_MASK) == `BIE_INC_MATCH;
        k = (i & `BIE_INCSZ_MASK) == `BIE_INCSZ_MATCH;
        b = (i & `BIE_BR_MASK) == `BIE_BR_MATCH;
        x = d | n | k;
        v = exp_step(i, f);
        insn_in = i;
        file_data_in = f;
        status_in = s;
        insn_valid_in = 1'b1;
        @(posedge core_clk_in);
        #2;
        `CHK(file_we_out, x & i[5])
        `CHK(acc_we_out, x & ~i[5])
        if (x) `CHK({result_out, file_addr_out}, {v, i[4:0]})
        `CHK(zero_we_out, d | n)
        if (d | n) `CHK(zero_out, v == 8'h00)
        `CHK(pc_load_out, b)
        if (b) `CHK(pc_target_out, exp_tgt(i, s))
        `CHK({squash_out, busy_out}, {2{b | (k & v == 8'h00)}})
        if (busy_out === 1'b1) begin
            insn_in = 12'h2bf;
            @(posedge core_clk_in);
            #2;
            `CHK({file_we_out, pc_load_out, busy_out}, 3'h0)
        end
    endtask
    initial begin
        repeat (8) @(posedge core_clk_in);
        #2;
        resetn_in = 1'b1;
        run(12'h2a5, 8'hff, 8'h00);
        run(12'h0e3, 8'h01, 8'h00);
        run(12'h0c3, 8'h00, 8'h00);
        run(12'ha10, 8'h00, 8'h60);
        run(12'hbff, 8'h00, 8'h9f);
        run(12'h3e5, 8'hff, 8'h00);
        run(12'h3c5, 8'h10, 8'h00);
        run(12'h145, 8'hff, 8'h00);
        $display("corner test done");
        // reset again in mid-run, then a step word without valid
        resetn_in = 1'b0;
        insn_valid_in = 1'b0;
        repeat (2) @(posedge core_clk_in);
        #2;
        `CHK({busy_out, pc_load_out, file_we_out, zero_out}, 4'h0)
        resetn_in = 1'b1;
        insn_in = 12'h2a5;
        file_data_in = 8'hff;
        @(posedge core_clk_in);
        #2;
        `CHK({acc_we_out, file_we_out, zero_we_out}, 3'h0)
        for (int j = 0; j < 300; j++) begin
            r = $random(seed);
            op = ops[r[30:28] % 5];
            run(op | (r[11:0] & (op == `BIE_BR_MATCH ? 12'h1ff : 12'h03f)),
                r[19:18] == 2'b00 ? 8'hff : r[27:20], r[31:24]);
        end
        $display("random test done");
        wrap_up();
    end
endmodule
bind bie_exec bie_exec_props props_u (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .insn_in(insn_in), .insn_valid_in(insn_valid_in),
    .file_data_in(file_data_in), .status_in(status_in),
    .result_out(result_out), .acc_we_out(acc_we_out),
    .file_we_out(file_we_out), .zero_we_out(zero_we_out),
    .zero_out(zero_out), .pc_load_out(pc_load_out),
    .pc_target_out(pc_target_out), .squash_out(squash_out),
    .busy_out(busy_out));
